// ===== ett_timer_bank.sv
// Bank of sixteen elapsed timers with trigger requests and register port.
module ett_timer_bank
    import ett_pkg::*;
#(
    parameter int unsigned TICK_CNT = TICK_CYCLES
) (
    // Clock and resets
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              pwr_on_rst,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // Trigger message requests
    output logic                   trig_req,
    output logic      [IDX_W-1:0]  trig_idx,
    output logic      [MSG_W-1:0]  trig_msg,
    input  wire logic              trig_ack,
    // Snapshot port for transmission and remote mirror
    input  wire logic              snap_req,
    input  wire logic [IDX_W-1:0]  snap_idx,
    output logic                   snap_valid,
    output logic                   snap_run,
    output logic                   snap_up,
    output logic      [VAL_W-1:0]  snap_value,
    // Status
    output logic [NUM_TIMERS-1:0]  ovf_flags,
    output logic [NUM_TIMERS-1:0]  run_flags
);

    // =================================================================
    // State
    typedef struct packed {
        ett_timer_t [NUM_TIMERS-1:0] tm;
        logic                        req_vld;
        ett_idx_t                    req_idx;
        logic [MSG_W-1:0]            req_msg;
        ett_idx_t                    rr;
        logic [DATA_W-1:0]           rdata;
        logic                        snap_vld;
        logic                        snap_run;
        logic                        snap_up;
        logic [VAL_W-1:0]            snap_val;
        logic [DATA_W-1:0]           ticks;
    } ett_state_t;

    ett_state_t q;
    ett_state_t d;

    ett_tick_if tick_bus ();

    ett_prescaler #(
        .CYCLES (TICK_CNT)
    ) u_prescaler (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .tick_out (tick_bus)
    );

    // =================================================================
    // Address decode.
    logic       page_glob;
    ett_idx_t   sel_idx;
    logic [1:0] sel_reg;

    assign page_glob = reg_addr[PAGE_BIT];
    assign sel_idx   = reg_addr[5:2];
    assign sel_reg   = reg_addr[1:0];

    // =================================================================
    // Next state.
    always_comb begin
        ett_timer_t       t;
        logic [VAL_W-1:0] nxt;
        logic             loaded;
        logic             found;
        ett_idx_t         pick;
        ett_idx_t         cand;

        t      = '0;
        nxt    = VAL_ZERO;
        loaded = 1'b0;
        found  = 1'b0;
        pick   = '0;
        cand   = '0;

        d          = q;
        d.rdata    = '0;
        d.snap_vld = 1'b0;

        // Arbiter: a held request drops on accept; a new one is picked
        // only when none is held, so requests never overlap.
        if (q.req_vld && trig_ack) begin
            d.req_vld = 1'b0;
        end
        if (!q.req_vld) begin
            for (int k = 0; k < NUM_TIMERS; k++) begin
                cand = q.rr + IDX_W'(k);
                if (!found && q.tm[cand].pend) begin
                    found = 1'b1;
                    pick  = cand;
                end
            end
            if (found) begin
                d.req_vld = 1'b1;
                d.req_idx = pick;
                d.req_msg = q.tm[pick].msg;
                d.rr      = pick + IDX_W'(1);
            end
        end

        if (tick_bus.tick) begin
            d.ticks = q.ticks + DATA_W'(1);
        end

        for (int i = 0; i < NUM_TIMERS; i++) begin
            t      = q.tm[i];
            loaded = 1'b0;

            // A pending request is consumed when it is issued.
            if (found && pick == IDX_W'(i)) begin
                t.pend = 1'b0;
            end

            // Register writes.
            if (reg_wr && !page_glob && sel_idx == IDX_W'(i)) begin
                unique case (sel_reg)
                    REG_CTRL: begin
                        t.run     = reg_wdata[CB_RUN];
                        t.up      = reg_wdata[CB_UP];
                        t.trig_en = reg_wdata[CB_TEN];
                        t.retrig  = reg_wdata[CB_RETRIG];
                        t.save    = reg_wdata[CB_SAVE];
                        if (reg_wdata[CB_OVF]) begin
                            t.ovf = 1'b0;
                        end
                    end
                    REG_VALUE: begin
                        t.value = (reg_wdata > VAL_MAX) ? VAL_MAX : reg_wdata;
                        loaded  = 1'b1;
                    end
                    REG_TRIG: begin
                        t.trig_val = (reg_wdata > VAL_MAX) ? VAL_MAX : reg_wdata;
                    end
                    REG_MSG: begin
                        t.msg = reg_wdata[MSG_W-1:0];
                    end
                endcase
            end
            if (reg_wr && page_glob && sel_reg == GREG_RUN) begin
                t.run = reg_wdata[i];
            end

            // Advance on the tick; a load in the same cycle wins.
            if (tick_bus.tick && t.run && !loaded) begin
                if (t.up) begin
                    if (t.value == VAL_MAX) begin
                        nxt   = VAL_ZERO;
                        t.ovf = 1'b1;
                    end else begin
                        nxt = t.value + VAL_W'(1);
                    end
                end else begin
                    if (t.value == VAL_ZERO) begin
                        nxt   = VAL_MAX;
                        t.ovf = 1'b1;
                    end else begin
                        nxt = t.value - VAL_W'(1);
                    end
                end
                // Only reaching the value while enabled fires.
                if (t.trig_en && nxt == t.trig_val) begin
                    t.pend = 1'b1;
                    if (t.retrig) begin
                        nxt = VAL_ZERO;
                    end else begin
                        t.trig_en = 1'b0;
                    end
                end
                t.value = nxt;
            end

            // Reset by disposition.
            if (rst && !t.save) begin
                t.run      = 1'b0;
                t.up       = 1'b0;
                t.trig_en  = 1'b0;
                t.retrig   = 1'b0;
                t.ovf      = 1'b0;
                t.pend     = 1'b0;
                t.value    = VAL_ZERO;
                t.trig_val = VAL_ZERO;
                t.msg      = '0;
            end else if (rst) begin
                t = q.tm[i];
            end
            d.tm[i] = t;
        end

        // Register reads: one coherent copy, answered next cycle.
        if (reg_rd) begin
            if (!page_glob) begin
                unique case (sel_reg)
                    REG_CTRL: begin
                        d.rdata[CB_RUN]    = q.tm[sel_idx].run;
                        d.rdata[CB_UP]     = q.tm[sel_idx].up;
                        d.rdata[CB_TEN]    = q.tm[sel_idx].trig_en;
                        d.rdata[CB_RETRIG] = q.tm[sel_idx].retrig;
                        d.rdata[CB_SAVE]   = q.tm[sel_idx].save;
                        d.rdata[CB_OVF]    = q.tm[sel_idx].ovf;
                        d.rdata[CB_PEND]   = q.tm[sel_idx].pend;
                    end
                    REG_VALUE: begin
                        d.rdata = q.tm[sel_idx].value;
                    end
                    REG_TRIG: begin
                        d.rdata = q.tm[sel_idx].trig_val;
                    end
                    REG_MSG: begin
                        d.rdata[MSG_W-1:0] = q.tm[sel_idx].msg;
                    end
                endcase
            end else begin
                unique case (sel_reg)
                    GREG_FLAGS: begin
                        for (int i = 0; i < NUM_TIMERS; i++) begin
                            d.rdata[i]              = q.tm[i].ovf;
                            d.rdata[i + NUM_TIMERS] = q.tm[i].pend;
                        end
                    end
                    GREG_RUN: begin
                        for (int i = 0; i < NUM_TIMERS; i++) begin
                            d.rdata[i] = q.tm[i].run;
                        end
                    end
                    GREG_TICKS: begin
                        d.rdata = q.ticks;
                    end
                    default: begin
                        d.rdata = '0;
                    end
                endcase
            end
        end

        // Snapshot for transmission and remote mirror.
        if (snap_req) begin
            d.snap_vld = 1'b1;
            d.snap_run = q.tm[snap_idx].run;
            d.snap_up  = q.tm[snap_idx].up;
            d.snap_val = q.tm[snap_idx].value;
        end

        if (rst) begin
            d.req_vld  = 1'b0;
            d.req_idx  = '0;
            d.req_msg  = '0;
            d.rr       = '0;
            d.rdata    = '0;
            d.snap_vld = 1'b0;
            d.snap_run = 1'b0;
            d.snap_up  = 1'b0;
            d.snap_val = VAL_ZERO;
            d.ticks    = '0;
        end
        if (pwr_on_rst) begin
            d = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        q <= d;
    end

    // =================================================================
    // Outputs.
    assign reg_rdata  = q.rdata;
    assign trig_req   = q.req_vld;
    assign trig_idx   = q.req_idx;
    assign trig_msg   = q.req_msg;
    assign snap_valid = q.snap_vld;
    assign snap_run   = q.snap_run;
    assign snap_up    = q.snap_up;
    assign snap_value = q.snap_val;

    for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_flags
        assign ovf_flags[g] = q.tm[g].ovf;
        assign run_flags[g] = q.tm[g].run;
    end

endmodule : ett_timer_bank

// ===== ett_pkg.sv
// Constants, types and field layout for the elapsed timer bank.
// =====================================================================
// Notes on behaviour
// - Sixteen independent timers, each advanced by its own current settings.
// - Save disposition: reset keeps configuration, value and run state.
// - Clear disposition: reset stops, sets down, zeroes value, clears triggers.
// - Starting or stopping a timer leaves its value unchanged.
// - Direction up or down may change while running.
// - Value in hundredths of a second, zero to 9999:59:59.99.
// - A new value may be loaded at any time, even while running.
// - Up from maximum wraps to zero and sets the wrap flag.
// - Down from zero wraps to maximum and sets the wrap flag.
// - The wrap flag stays set until software clears it.
// - Enabled trigger raises a message request when value equals trigger value.
// - One-shot: after the request, trigger turns off, timer runs on unchanged.
// - Retrigger: after the request, value returns to zero, trigger stays on.
// - Trigger value spans the same range as the value.
// - Only reaching the trigger value while enabled fires; late enable does not.
// - Each timer has a rewritable message number; numbers may be shared.
// - Pending requests go out one at a time, round-robin from the timer after the last one issued.
// - A value read gives one coherent instantaneous snapshot.
// - The bank supplies run status and value for a remote mirror.
// =====================================================================
package ett_pkg;

    // =================================================================
    // Sizes
    localparam int NUM_TIMERS = 16;
    localparam int IDX_W      = 4;
    localparam int VAL_W      = 32;
    localparam int MSG_W      = 10;
    localparam int ADDR_W     = 7;
    localparam int DATA_W     = 32;

    // =================================================================
    // Value range in hundredths of a second.
    localparam logic [VAL_W-1:0] VAL_MAX  = 32'hd693a3ff;
    localparam logic [VAL_W-1:0] VAL_ZERO = 32'h0000_0000;

    // =================================================================
    // Tick timing.
    localparam int unsigned CLK_HZ      = 20_000_000;
    localparam int unsigned TICK_MS     = 10;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    // =================================================================
    // Register map: address bit 6 picks the global page, bits 5:2 the
    // timer and bits 1:0 the register within a timer.
    localparam int          PAGE_BIT   = 6;
    localparam logic [1:0]  REG_CTRL   = 2'h0;
    localparam logic [1:0]  REG_VALUE  = 2'h1;
    localparam logic [1:0]  REG_TRIG   = 2'h2;
    localparam logic [1:0]  REG_MSG    = 2'h3;
    localparam logic [1:0]  GREG_FLAGS = 2'h0;
    localparam logic [1:0]  GREG_RUN   = 2'h1;
    localparam logic [1:0]  GREG_TICKS = 2'h2;

    // =================================================================
    // Control register bit positions.
    localparam int CB_RUN    = 0;
    localparam int CB_UP     = 1;
    localparam int CB_TEN    = 2;
    localparam int CB_RETRIG = 3;
    localparam int CB_SAVE   = 4;
    localparam int CB_OVF    = 5;
    localparam int CB_PEND   = 6;

    // =================================================================
    // Types
    typedef logic [IDX_W-1:0] ett_idx_t;

    typedef struct packed {
        logic             run;
        logic             up;
        logic             trig_en;
        logic             retrig;
        logic             save;
        logic             ovf;
        logic             pend;
        logic [VAL_W-1:0] value;
        logic [VAL_W-1:0] trig_val;
        logic [MSG_W-1:0] msg;
    } ett_timer_t;

endpackage : ett_pkg

// ===== ett_tick_if.sv
// Interface carrying the 10 ms tick between prescaler and timer bank.
interface ett_tick_if;
    logic tick;

    modport src (output tick);
    modport snk (input tick);
endinterface : ett_tick_if

// ===== ett_prescaler.sv
// Prescaler that divides the system clock down to the timer tick.
module ett_prescaler
    import ett_pkg::*;
#(
    parameter int unsigned CYCLES = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Tick out
    ett_tick_if.src   tick_out
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } ett_pre_state_t;

    ett_pre_state_t q;
    ett_pre_state_t d;

    // =================================================================
    // Divider: one tick pulse every CYCLES clocks.
    always_comb begin
        d      = q;
        d.tick = 1'b0;
        if (q.cnt == LAST) begin
            d.cnt  = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + CW'(1);
        end
        if (rst) begin
            d = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        q <= d;
    end

    assign tick_out.tick = q.tick;

endmodule : ett_prescaler

// ===== ett_timer_bank_props.sv
// Concurrent checks on the ports of the elapsed timer bank.
module ett_timer_bank_props
    import ett_pkg::*;
#(
    parameter int unsigned TICK_CNT = TICK_CYCLES
) (
    // Clock and resets
    input wire logic                  sys_clk,
    input wire logic                  rst,
    input wire logic                  pwr_on_rst,
    // Register port
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [DATA_W-1:0]     reg_rdata,
    // Trigger requests
    input wire logic                  trig_req,
    input wire logic [IDX_W-1:0]      trig_idx,
    input wire logic [MSG_W-1:0]      trig_msg,
    input wire logic                  trig_ack,
    // Snapshot and status
    input wire logic                  snap_req,
    input wire logic                  snap_valid,
    input wire logic [VAL_W-1:0]      snap_value,
    input wire logic [NUM_TIMERS-1:0] ovf_flags,
    input wire logic [NUM_TIMERS-1:0] run_flags
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst || pwr_on_rst);

    // =================================================================
    // Request handshake
    sequence s_held;
        trig_req && !trig_ack;
    endsequence
    sequence s_taken;
        trig_req && trig_ack;
    endsequence

    req_hold_a:
        assert property (s_held |=> trig_req && $stable(trig_idx) && $stable(trig_msg))
        else $error("request changed before accept");
    req_drop_a:
        assert property (s_taken |=> !trig_req)
        else $error("request stayed after accept");

    // =================================================================
    // Snapshot, register data and flags
    snap_pulse_a:
        assert property (snap_req |=> snap_valid)
        else $error("snapshot not answered");
    snap_quiet_a:
        assert property (!snap_req |=> !snap_valid)
        else $error("snapshot valid without request");
    snap_hold_a:
        assert property (!snap_req |=> $stable(snap_value))
        else $error("snapshot value moved");
    rdata_idle_a:
        assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data without read");
    ovf_sticky_a:
        assert property (!reg_wr |=> (ovf_flags & $past(ovf_flags)) == $past(ovf_flags))
        else $error("wrap flag cleared without write");
    run_stable_a:
        assert property (!reg_wr |=> $stable(run_flags))
        else $error("run state changed without write");
endmodule : ett_timer_bank_props

bind ett_timer_bank ett_timer_bank_props #(.TICK_CNT(TICK_CNT)) ett_timer_bank_props_inst (
    .sys_clk(sys_clk), .rst(rst), .pwr_on_rst(pwr_on_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trig_req(trig_req), .trig_idx(trig_idx), .trig_msg(trig_msg),
    .trig_ack(trig_ack), .snap_req(snap_req), .snap_valid(snap_valid), .snap_value(snap_value),
    .ovf_flags(ovf_flags), .run_flags(run_flags));

// ===== ett_msg_engine_model.sv
// Behavioural message engine that accepts trigger requests.
module ett_msg_engine_model
    import ett_pkg::*;
(
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // Trigger requests
    input  wire logic             trig_req,
    input  wire logic [IDX_W-1:0] trig_idx,
    input  wire logic [MSG_W-1:0] trig_msg,
    output logic                  trig_ack,
    // Accept latency and log
    input  wire logic [7:0]       lat,
    output int                    n_acc,
    output logic      [IDX_W-1:0] last_idx,
    output logic      [MSG_W-1:0] last_msg
);
    logic [7:0] wait_q;

    // Accepts a held request after lat cycles with a one-cycle pulse.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            trig_ack <= 1'b0;
            wait_q <= 8'h00;
            n_acc <= 0;
        end else if (trig_req && !trig_ack && wait_q >= lat) begin
            trig_ack <= 1'b1;
            wait_q <= 8'h00;
            n_acc <= n_acc + 1;
            last_idx <= trig_idx;
            last_msg <= trig_msg;
        end else begin
            trig_ack <= 1'b0;
            wait_q <= (trig_req && !trig_ack) ? wait_q + 8'h01 : 8'h00;
        end
    end
endmodule : ett_msg_engine_model

// ===== ett_timer_bank_tb_top.sv
// Self-checking testbench for the elapsed timer bank.
module ett_timer_bank_tb_top
    import ett_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    `define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
        $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

    logic                  sys_clk = 1'b0;
    logic                  rst = 1'b1;
    logic                  pwr_on_rst = 1'b1;
    logic                  reg_wr = 1'b0;
    logic                  reg_rd = 1'b0;
    logic                  snap_req = 1'b0;
    logic [ADDR_W-1:0]     reg_addr = '0;
    logic [DATA_W-1:0]     reg_wdata = '0;
    logic [DATA_W-1:0]     reg_rdata;
    logic [DATA_W-1:0]     d;
    logic [IDX_W-1:0]      snap_idx = '0;
    logic [IDX_W-1:0]      trig_idx;
    logic [IDX_W-1:0]      last_idx;
    logic [MSG_W-1:0]      trig_msg;
    logic [MSG_W-1:0]      last_msg;
    logic                  trig_req;
    logic                  trig_ack;
    logic                  snap_valid;
    logic                  snap_run;
    logic                  snap_up;
    logic [VAL_W-1:0]      snap_value;
    logic [NUM_TIMERS-1:0] ovf_flags;
    logic [NUM_TIMERS-1:0] run_flags;
    logic [7:0]            lat = 8'h00;
    int                    n_acc;
    int                    n_fail = 0;
    int                    compares = 0;

    ett_timer_bank #(.TICK_CNT(10)) ett_timer_bank_inst (.sys_clk, .rst, .pwr_on_rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .trig_req, .trig_idx, .trig_msg, .trig_ack,
        .snap_req, .snap_idx, .snap_valid, .snap_run, .snap_up, .snap_value, .ovf_flags, .run_flags);
    ett_msg_engine_model ett_msg_engine_model_inst (.sys_clk, .rst(rst | pwr_on_rst), .trig_req,
        .trig_idx, .trig_msg, .trig_ack, .lat, .n_acc, .last_idx, .last_msg);

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    // =================================================================
    // Bus and wait helpers
    function automatic logic [6:0] ta(input int t, input logic [1:0] r);
        return {1'b0, 4'(t), r};
    endfunction : ta
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc
    task automatic wr(input logic [6:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [6:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    task automatic wovf(input int t);
        int k;
        for (k = 0; k < 500 && ovf_flags[t] !== 1'b1; k++) @(posedge sys_clk);
        if (k == 500) begin
            n_fail++;
            print_verdict();
        end
    endtask : wovf
    task automatic wacc(input int n);
        int k;
        for (k = 0; k < 500 && n_acc < n; k++) @(posedge sys_clk);
        if (k == 500) begin
            n_fail++;
            print_verdict();
        end
    endtask : wacc

    // =================================================================
    // Scenarios
    task automatic t_count;
        wr(ta(1, REG_CTRL), 32'h3);
        wr(ta(1, REG_VALUE), VAL_MAX);
        wovf(1);
        cyc(22);
        rd(ta(1, REG_VALUE));
        `CHK("up wrap count", 32'h2, d)
        wr(ta(1, REG_CTRL), 32'h21);
        cyc(1);
        wovf(1);
        cyc(2);
        rd(ta(1, REG_VALUE));
        `CHK("down wrap", VAL_MAX, d)
        wr(ta(1, REG_CTRL), 32'h0);
        cyc(30);
        rd(ta(1, REG_VALUE));
        `CHK("stopped value", VAL_MAX, d)
        rd(ta(1, REG_CTRL));
        `CHK("flag held", 32'h20, d)
        rd(7'h40);
        `CHK("flag summary", 32'h2, d)
        wr(ta(1, REG_CTRL), 32'h20);
        cyc(1);
        #1 `CHK("flag cleared", 1'b0, ovf_flags[1])
        wr(ta(2, REG_VALUE), VAL_MAX + 32'h1);
        rd(ta(2, REG_VALUE));
        `CHK("value limit", VAL_MAX, d)
        wr(ta(2, REG_TRIG), 32'hffff_ffff);
        rd(ta(2, REG_TRIG));
        `CHK("trigger limit", VAL_MAX, d)
        rd(7'h43);
        `CHK("unmapped read", 32'h0, d)
        $display("count test done");
    endtask : t_count

    task automatic t_trig;
        lat <= 8'h05;
        for (int t = 0; t <= 12; t += 12) begin
            wr(ta(4'(t), REG_CTRL), 32'h6);
            wr(ta(4'(t), REG_TRIG), 32'h3);
            wr(ta(4'(t), REG_MSG), 32'h11);
        end
        wr(7'h41, 32'h1001);
        wacc(1);
        `CHK("first index", 4'h0, last_idx)
        `CHK("run mask", 16'h1001, run_flags)
        `CHK("first message", 10'h011, last_msg)
        wacc(2);
        `CHK("second index", 4'hc, last_idx)
        `CHK("shared message", 10'h011, last_msg)
        rd(ta(0, REG_CTRL));
        `CHK("one shot ctrl", 32'h3, d)
        $display("trigger test done");
    endtask : t_trig

    task automatic t_retrig;
        lat <= 8'h00;
        wr(ta(5, REG_TRIG), 32'h2);
        wr(ta(5, REG_MSG), 32'h5);
        wr(ta(5, REG_CTRL), 32'hf);
        wacc(3);
        `CHK("retrig index", 4'h5, last_idx)
        wr(ta(5, REG_MSG), 32'h77);
        wacc(5);
        `CHK("new message", 10'h077, last_msg)
        rd(ta(5, REG_CTRL));
        `CHK("retrig ctrl", 32'hf, d)
        rd(ta(5, REG_VALUE));
        `CHK("retrig value", 1'b1, d < 32'h2)
        wr(ta(5, REG_CTRL), 32'he);
        wr(ta(7, REG_VALUE), 32'ha);
        wr(ta(7, REG_TRIG), 32'h5);
        wr(ta(7, REG_CTRL), 32'h3);
        cyc(5);
        wr(ta(7, REG_CTRL), 32'h7);
        cyc(80);
        `CHK("late enable", 5, n_acc)
        $display("retrigger test done");
    endtask : t_retrig

    task automatic t_reset;
        wr(ta(9, REG_CTRL), 32'h13);
        @(posedge sys_clk);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        rd(ta(9, REG_CTRL));
        `CHK("saved ctrl", 32'h13, d)
        rd(ta(5, REG_CTRL));
        `CHK("cleared ctrl", 32'h0, d)
        rd(ta(5, REG_TRIG));
        `CHK("cleared trigger", 32'h0, d)
        rd(ta(7, REG_VALUE));
        `CHK("cleared value", 32'h0, d)
        @(posedge sys_clk);
        snap_idx <= 4'h9;
        snap_req <= 1'b1;
        reg_addr <= ta(9, REG_VALUE);
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        snap_req <= 1'b0;
        reg_rd <= 1'b0;
        #1 `CHK("snap valid", 1'b1, snap_valid)
        `CHK("snap status", 2'b11, {snap_run, snap_up})
        `CHK("snap value", reg_rdata, snap_value)
        rd(7'h42);
        `CHK("tick count", 32'h1, d)
        $display("reset test done");
    endtask : t_reset

    initial begin
        cyc(16);
        pwr_on_rst <= 1'b0;
        rst <= 1'b0;
        cyc(2);
        t_count();
        t_trig();
        t_retrig();
        t_reset();
        print_verdict();
    end
endmodule : ett_timer_bank_tb_top
